// File: rtl/hb_spi_pkg.sv
// constants, field positions and carrier types for the half-bridge serial control block
package hb_spi_pkg;

	// serial word and frame length
	localparam int         WORD_BITS = 16;
	localparam int         CNT_W     = 5;
	localparam logic [4:0] FRAME_MIN = 5'h10;

	// command word field positions
	localparam int B_OVSD   = 15;
	localparam int B_ULSD   = 14;
	localparam int B_OCD    = 13;
	localparam int B_DRV_HI = 6;
	localparam int B_DRV_LO = 1;
	localparam int B_CLR    = 0;

	// status word field positions
	localparam int B_PSF = 15;
	localparam int B_ULD = 14;
	localparam int B_OC  = 13;
	localparam int B_STA = 12;
	localparam int B_TW  = 0;

	// driver counts
	localparam int DRV_N   = 6;
	localparam int BRIDGES = 3;

	// timing, in microseconds and megahertz
	localparam int REF_CLK_MHZ = 20;
	localparam int OC_SLOW_US  = 200;
	localparam int OC_FAST_US  = 25;
	localparam int FILTER_US   = 10;
	localparam int TMR_W       = 12;

	// reset values and the unused status field
	localparam logic [2:0]  CS_PIPE_RST = 3'h7;
	localparam logic [2:0]  EN_PIPE_RST = 3'h0;
	localparam logic [4:0]  UNUSED_OUT  = 5'h00;

	// latched command fields
	typedef struct packed {
		logic             ovShutEn;
		logic             uldShutEn;
		logic             ocFast;
		logic [DRV_N-1:0] drv;
	} cmd_t;

	// frame handed from the link domain
	typedef struct packed {
		logic [WORD_BITS-1:0] word;
		logic                 lenOk;
		logic                 tag;
	} link_rx_t;

endpackage

// File: rtl/link_shifter.sv
// serial-clock domain shifter, bit counter and daisy-chain output
`timescale 1ns/1ps
`default_nettype none
module link_shifter
	import hb_spi_pkg::*;
(
	input  wire logic                 sclk,
	input  wire logic                 reset_n,
	input  wire logic                 chip_select_n,
	input  wire logic                 serialIn,
	input  wire logic [WORD_BITS-1:0] statusWord,
	output logic                      serialOut,
	output logic                      serialOutEn,
	output link_rx_t                  rx
);

	logic                 armed_r;   // set while select high, first edge pending
	logic                 armClr;    // select high or reset
	logic [WORD_BITS-1:0] rxSh_r;    // received bits
	logic [WORD_BITS-1:0] txSh_r;    // outgoing bits
	logic [WORD_BITS-1:0] txBase;    // status on first edge, else shifter
	logic [CNT_W-1:0]     cnt_r;     // saturating frame bit count
	logic [CNT_W-1:0]     cntNxt;    // next count
	logic                 tag_r;     // flips once per frame with clocks

	////////////////////////////////////////////////////////////////////////////
	// arming: raised select re-arms, the first clock edge disarms
	assign armClr = chip_select_n | ~reset_n;

	always_ff @(posedge sclk or posedge armClr) begin
		if (armClr) begin
			armed_r <= 1'b1;
		end else begin
			armed_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next-value selection
	assign txBase = armed_r ? statusWord : txSh_r;
	assign cntNxt = armed_r ? CNT_W'(1) :
	                (cnt_r == FRAME_MIN) ? cnt_r : cnt_r + CNT_W'(1);

	// shifting on the rising clock edge, only inside a frame
	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			rxSh_r <= '0;
			txSh_r <= '0;
			cnt_r  <= '0;
			tag_r  <= 1'b0;
		end else if (!chip_select_n) begin
			rxSh_r <= {serialIn, rxSh_r[WORD_BITS-1:1]};
			txSh_r <= {serialIn, txBase[WORD_BITS-1:1]};
			cnt_r  <= cntNxt;
			tag_r  <= tag_r ^ armed_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs: bit 0 sits on the line before the first edge
	assign serialOut   = armed_r ? statusWord[0] : txSh_r[0];
	assign serialOutEn = ~chip_select_n;
	assign rx.word     = rxSh_r;
	assign rx.lenOk    = (cnt_r >= FRAME_MIN);
	assign rx.tag      = tag_r;

endmodule
`default_nettype wire

// File: rtl/half_bridge_spi_control.sv
// serial control, protection and fault reporting of a triple half-bridge driver
`timescale 1ns/1ps
`default_nettype none
module half_bridge_spi_control
	import hb_spi_pkg::*;
#(
	parameter int FILTER_CYC = FILTER_US * REF_CLK_MHZ
)(
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             sclk,
	input  wire logic             chip_select_n,
	input  wire logic             serialIn,
	output logic                  serialOut,
	output logic                  serialOutEn,
	input  wire logic             enable,
	input  wire logic             supplyFault,
	input  wire logic             overvoltage,
	input  wire logic             underload,
	input  wire logic [DRV_N-1:0] overcurrent,
	input  wire logic             thermalWarn,
	output logic      [DRV_N-1:0] driverOn,
	output logic                  driverHiZ
);

	////////////////////////////////////////////////////////////////////////////
	// derived timing counts
	localparam logic [TMR_W-1:0] OC_SLOW_CYC = TMR_W'(OC_SLOW_US * REF_CLK_MHZ);
	localparam logic [TMR_W-1:0] OC_FAST_CYC = TMR_W'(OC_FAST_US * REF_CLK_MHZ);
	localparam logic [TMR_W-1:0] FILT_CYC    = TMR_W'(FILTER_CYC);

	// agreed-level filter for a three-flop pin chain
	function automatic logic pin_level(input logic [2:0] pipe, input logic cur);
		pin_level = (pipe[1] == pipe[2]) ? pipe[2] : cur;
	endfunction

	// bridge mask: a blocked bridge drops both its drivers
	function automatic logic [DRV_N-1:0] bridge_mask(input logic [BRIDGES-1:0] blk);
		logic [DRV_N-1:0] m;
		m = '0;
		for (int i = 0; i < BRIDGES; i++) begin
			m[2*i]   = blk[i];
			m[2*i+1] = blk[i];
		end
		bridge_mask = m;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// declarations
	link_rx_t             rx;            // frame from the link domain
	logic [WORD_BITS-1:0] statusWord;    // live status word
	logic [WORD_BITS-1:0] statusSnap_r;  // frozen copy seen by the link
	logic [2:0]           csPipe_r;      // select synchroniser
	logic [2:0]           enPipe_r;      // enable synchroniser
	logic                 csLevel_r;     // agreed select level
	logic                 csLevel_nxt;   // next agreed select level
	logic                 enLevel_r;     // agreed enable level
	logic                 enLevel_nxt;   // next agreed enable level
	logic                 tagSeen_r;     // frame tag at last select rise
	logic                 frameEnd;      // select rose this cycle
	logic                 frameValid;    // frame passes the length check
	logic                 clr;           // valid frame with clear bit
	cmd_t                 cmd_r;         // latched command fields
	cmd_t                 cmd_nxt;       // command fields of the new word
	logic [BRIDGES-1:0]   stTry;         // bridges commanded both on
	logic [BRIDGES-1:0]   stBlock_r;     // bridges held off
	logic [TMR_W-1:0]     filtCnt_r;     // fault filter timer
	logic                 filtDone;      // filter time elapsed
	logic                 psf_r;         // supply-fail flag
	logic                 uld_r;         // underload flag
	logic                 tw_r;          // thermal warning flag
	logic                 oc_r;          // overcurrent flag
	logic [DRV_N-1:0]     ocLatch_r;     // drivers latched off
	logic [DRV_N-1:0]     ocTrip;        // overcurrent delay reached
	logic [TMR_W-1:0]     ocLimit;       // selected overcurrent delay
	logic [TMR_W-1:0]     ocCnt_r [DRV_N]; // per-driver overcurrent timers
	logic                 ovOff;         // overvoltage shutdown active
	logic                 uldOff;        // underload shutdown active
	logic [DRV_N-1:0]     driveMask;     // drivers allowed on
	logic [DRV_N-1:0]     driverOn_r;    // registered driver states
	logic                 driverHiZ_r;   // registered sleep state

	////////////////////////////////////////////////////////////////////////////
	// link-clock logic; the frozen status snapshot is what it shifts out
	link_shifter u_link (
		.sclk          (sclk),
		.reset_n       (reset_n),
		.chip_select_n (chip_select_n),
		.serialIn      (serialIn),
		.statusWord    (statusSnap_r),
		.serialOut     (serialOut),
		.serialOutEn   (serialOutEn),
		.rx            (rx)
	);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; select idles high, enable idles low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			csPipe_r <= CS_PIPE_RST;
			enPipe_r <= EN_PIPE_RST;
		end else begin
			csPipe_r <= {csPipe_r[1:0], chip_select_n};
			enPipe_r <= {enPipe_r[1:0], enable};
		end
	end

	// agreed levels
	assign csLevel_nxt = pin_level(csPipe_r, csLevel_r);
	assign enLevel_nxt = pin_level(enPipe_r, enLevel_r);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			csLevel_r <= 1'b1;
			enLevel_r <= 1'b0;
		end else begin
			csLevel_r <= csLevel_nxt;
			enLevel_r <= enLevel_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame end; the link word is stable since the clock stays low
	assign frameEnd   = csLevel_nxt & ~csLevel_r;
	// a frame with no clock leaves the tag unchanged and is dropped
	assign frameValid = frameEnd & rx.lenOk & (rx.tag != tagSeen_r);
	assign clr        = frameValid & rx.word[B_CLR];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tagSeen_r <= 1'b0;
		end else if (frameEnd) begin
			tagSeen_r <= rx.tag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command fields of the received word; bits 12 to 7 ignored
	assign cmd_nxt.ovShutEn  = rx.word[B_OVSD];
	assign cmd_nxt.uldShutEn = rx.word[B_ULSD];
	assign cmd_nxt.ocFast    = rx.word[B_OCD];
	assign cmd_nxt.drv       = rx.word[B_DRV_HI:B_DRV_LO];

	// command register: loaded only by a valid frame
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_r <= '0;
		end else if (frameValid) begin
			cmd_r <= cmd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shoot-through detection per bridge
	always_comb begin
		stTry = '0;
		for (int i = 0; i < BRIDGES; i++) begin
			stTry[i] = frameValid & cmd_nxt.drv[2*i] & cmd_nxt.drv[2*i+1];
		end
	end

	// block held until a clear; a new attempt wins over the clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stBlock_r <= '0;
		end else begin
			stBlock_r <= stTry | (stBlock_r & {BRIDGES{~clr}});
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fault filter: restarts on a valid frame, flags relatch after it
	assign filtDone = (filtCnt_r == FILT_CYC);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			filtCnt_r <= '0;
		end else if (frameValid) begin
			filtCnt_r <= '0;
		end else if (!filtDone) begin
			filtCnt_r <= filtCnt_r + TMR_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// overcurrent timers; the delay follows the command bit
	assign ocLimit = cmd_r.ocFast ? OC_FAST_CYC : OC_SLOW_CYC;

	always_comb begin
		ocTrip = '0;
		for (int i = 0; i < DRV_N; i++) begin
			ocTrip[i] = overcurrent[i] & driverOn_r[i] & (ocCnt_r[i] >= ocLimit);
		end
	end

	// each timer runs while its driver is on and overloaded
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DRV_N; i++) begin
				ocCnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DRV_N; i++) begin
				if (!(overcurrent[i] && driverOn_r[i])) begin
					ocCnt_r[i] <= '0;
				end else if (ocCnt_r[i] < ocLimit) begin
					ocCnt_r[i] <= ocCnt_r[i] + TMR_W'(1);
				end
			end
		end
	end

	// latch-off per driver, released by the clear bit; trip wins
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ocLatch_r <= '0;
		end else begin
			ocLatch_r <= ocTrip | (ocLatch_r & {DRV_N{~clr}});
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags; each set wins over its clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			psf_r <= 1'b0;
			uld_r <= 1'b0;
			tw_r  <= 1'b0;
			oc_r  <= 1'b0;
		end else begin
			// supply fail sticks until the clear bit
			psf_r <= (filtDone & supplyFault) | (psf_r & ~clr);
			// underload and thermal drop on any valid frame
			uld_r <= (filtDone & underload) | (uld_r & ~frameValid);
			tw_r  <= (filtDone & thermalWarn) | (tw_r & ~frameValid);
			// overcurrent reported with its latch-off
			oc_r  <= (|ocTrip) | (oc_r & ~clr);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// driver gating
	assign ovOff     = cmd_r.ovShutEn & overvoltage;
	assign uldOff    = cmd_r.uldShutEn & uld_r;
	assign driveMask = ~ocLatch_r & ~bridge_mask(stBlock_r) &
	                   {DRV_N{enLevel_r & ~ovOff & ~uldOff}};

	// programmed states are kept; outputs follow the mask
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			driverOn_r  <= '0;
			driverHiZ_r <= 1'b1;
		end else begin
			driverOn_r  <= cmd_r.drv & driveMask;
			driverHiZ_r <= ~enLevel_r;
		end
	end

	assign driverOn  = driverOn_r;
	assign driverHiZ = driverHiZ_r;

	////////////////////////////////////////////////////////////////////////////
	// status word and its frozen copy for the link
	assign statusWord = {psf_r, uld_r, oc_r, |stBlock_r,
	                     UNUSED_OUT, driverOn_r, tw_r};

	// the copy holds still while a frame is open
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			statusSnap_r <= '0;
		end else if (csLevel_r) begin
			statusSnap_r <= statusWord;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// a checked word reaches the command register
	a_frame_load: assert property (
		frameValid |=> cmd_r.drv == $past(rx.word[B_DRV_HI:B_DRV_LO]))
		else $error("command not loaded from valid frame");

	// a short frame leaves command and latches alone
	a_short_frame: assert property (
		(frameEnd && !rx.lenOk) |=> ($stable(cmd_r) && $stable(ocLatch_r)))
		else $error("short frame changed state");

	// overvoltage shutdown forces every driver off
	a_ov_off: assert property (
		(cmd_r.ovShutEn && overvoltage) |=> driverOn_r == '0)
		else $error("driver on during overvoltage shutdown");

	// supply fail holds until a clear
	a_psf_hold: assert property (
		(psf_r && !clr) |=> psf_r)
		else $error("supply fail dropped without clear");

	// a blocked bridge 0 keeps both its drivers off
	a_st_block: assert property (
		stBlock_r[0] |=> driverOn_r[1:0] == 2'b00)
		else $error("blocked bridge driver on");

	// a latched driver stays off next cycle
	a_oc_latch: assert property (
		(|ocLatch_r) |=> (driverOn_r & $past(ocLatch_r)) == '0)
		else $error("latched driver turned on");

	// sleep turns every driver off on the next cycle
	a_sleep_off: assert property (
		!enLevel_r |=> (driverOn_r == '0 && driverHiZ_r))
		else $error("driver active in sleep");

	// serial output released with select high
	a_so_release: assert property (
		chip_select_n |-> !serialOutEn)
		else $error("serial output driven with select high");

	// a valid frame drops the thermal warning flag unless it relatches
	a_tw_clear: assert property (
		(frameValid && !(filtDone && thermalWarn)) |=> !tw_r)
		else $error("thermal flag not cleared by valid frame");

	// the clear bit drops supply fail if no new fault
	a_clr_psf: assert property (
		(clr && !(filtDone && supplyFault)) |=> !psf_r)
		else $error("clear bit did not reset supply fail");

endmodule
`default_nettype wire

// File: bench/spi_host_model.sv
// host-side serial master model that frames commands for the half-bridge block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic      sclk,          // link clock, stands low outside frames
	output logic      chip_select_n, // frame select, active low
	output logic      serialIn,      // data toward the device
	input  wire logic serialOut,     // data from the device
	input  wire logic serialOutEn    // device drive enable of serialOut
);
	localparam int HALF = 40; // half of the 80 ns link period

	// idle levels: select pulled high, clock and data pulled low
	initial begin
		sclk          = 1'b0;
		chip_select_n = 1'b1;
		serialIn      = 1'b0;
	end

	// one frame of nBits, lsb first; slow stretches the frame end
	task automatic xfer(input logic [31:0] tx, input int nBits, input int slow,
		output logic [31:0] rx, output logic enSeen);
		rx = 32'h0;
		chip_select_n = 1'b0;
		#(HALF);
		enSeen = serialOutEn;
		// one bit per clock pulse, data set while the clock is low
		for (int i = 0; i < nBits; i++) begin
			serialIn = tx[i];
			#(HALF / 2);
			rx[i] = serialOut;
			#(HALF / 2);
			sclk = 1'b1;
			#(HALF);
			sclk = 1'b0;
		end
		#(HALF + slow);
		chip_select_n = 1'b1;
		serialIn      = 1'b0; // released line falls to its pull-down
	endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the half-bridge serial control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin numErrors++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench
	import hb_spi_pkg::*;
;
	localparam int FILT = 4; // shortened fault filter

	logic             ref_clk       = 1'b0;  // system clock
	logic             reset_n       = 1'b0;  // async reset
	logic             enable        = 1'b0;  // sleep control
	logic             supplyFault   = 1'b0;  // supply fault level
	logic             overvoltage   = 1'b0;  // overvoltage level
	logic             underload     = 1'b0;  // underload level
	logic [DRV_N-1:0] overcurrent   = 6'h00; // per-driver overcurrent
	logic             thermalWarn   = 1'b0;  // thermal warning level
	wire              sclk;                  // link clock from host
	wire              chip_select_n;         // frame select
	wire              serialIn;              // host data
	logic             serialOut;             // device data
	logic             serialOutEn;           // device data enable
	logic [DRV_N-1:0] driverOn;              // driver gates
	logic             driverHiZ;             // sleep indication
	int               numErrors = 0;         // mismatches
	int               nChecks   = 0;         // comparisons
	int               dly;                   // overcurrent delay in cycles

	// 20 MHz system clock
	always #25 ref_clk = ~ref_clk;

	half_bridge_spi_control #(.FILTER_CYC(FILT)) dut (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.sclk          (sclk),
		.chip_select_n (chip_select_n),
		.serialIn      (serialIn),
		.serialOut     (serialOut),
		.serialOutEn   (serialOutEn),
		.enable        (enable),
		.supplyFault   (supplyFault),
		.overvoltage   (overvoltage),
		.underload     (underload),
		.overcurrent   (overcurrent),
		.thermalWarn   (thermalWarn),
		.driverOn      (driverOn),
		.driverHiZ     (driverHiZ)
	);

	spi_host_model host (
		.sclk          (sclk),
		.chip_select_n (chip_select_n),
		.serialIn      (serialIn),
		.serialOut     (serialOut),
		.serialOutEn   (serialOutEn)
	);

	////////////////////////////////////////////////////////////////////////////////
	// helper tasks

	// wait whole system clock cycles, ending at a falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// one frame: checks status word, chained bits and output release
	task automatic frame(input logic [31:0] tx, input int nBits, input logic [15:0] expStat);
		logic [31:0] rx;
		logic        en;
		@(negedge ref_clk);
		// a clockless frame holds select low long enough to be seen
		host.xfer(tx, nBits, (nBits == 0) ? 200 : nBits * 3, rx, en);
		`CHK(en, 1'b1)
		if (nBits >= 16) `CHK(rx[15:0], expStat)
		if (nBits == 24) `CHK(rx[23:16], tx[7:0])
		cyc(10);
		`CHK(serialOutEn, 1'b0)
	endtask

	// verdict and end of run
	task automatic closeOut();
		$display("checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence

	initial begin
		cyc(6);
		reset_n = 1'b1;
		`CHK(driverOn, 6'h00)
		`CHK(driverHiZ, 1'b1)
		`CHK(serialOutEn, 1'b0)
		enable = 1'b1;
		cyc(10);
		// plain word, then a short frame that must be dropped
		frame(32'h0012, 16, 16'h0000);
		`CHK(driverOn, 6'h09)
		frame(32'h0040, 15, 16'h0000);
		`CHK(driverOn, 6'h09)
		// long frame: last sixteen bits count, first bits pass through
		frame({16'h0022, 8'ha5}, 24, 16'h0012);
		`CHK(driverOn, 6'h11)
		// select pulse with no clock: saturated count must not pass it
		frame(32'h0000, 0, 16'h0000);
		`CHK(driverOn, 6'h11)
		// shoot-through on bridge 0, then clear
		frame(32'h000e, 16, 16'h0022);
		`CHK(driverOn, 6'h04)
		frame(32'h0009, 16, 16'h1008);
		frame(32'h8008, 16, 16'h0008);
		// overvoltage with shutdown enabled, then recovery
		overvoltage = 1'b1;
		supplyFault = 1'b1;
		cyc(10);
		`CHK(driverOn, 6'h00)
		overvoltage = 1'b0;
		supplyFault = 1'b0;
		cyc(10);
		`CHK(driverOn, 6'h04)
		frame(32'h0008, 16, 16'h8008);
		// overvoltage with shutdown disabled leaves drivers alone
		overvoltage = 1'b1;
		cyc(10);
		`CHK(driverOn, 6'h04)
		overvoltage = 1'b0;
		frame(32'h0009, 16, 16'h8008);
		// underload and thermal warning reporting and shutdown
		underload   = 1'b1;
		thermalWarn = 1'b1;
		cyc(10);
		frame(32'h0008, 16, 16'h4009);
		`CHK(driverOn, 6'h04)
		frame(32'h4008, 16, 16'h4009);
		`CHK(driverOn, 6'h00)
		underload   = 1'b0;
		thermalWarn = 1'b0;
		frame(32'h0009, 16, 16'h4001);
		`CHK(driverOn, 6'h04)
		// overcurrent latch-off for both delay selections
		for (int i = 0; i < 2; i++) begin
			dly = (i == 1) ? OC_FAST_US * REF_CLK_MHZ : OC_SLOW_US * REF_CLK_MHZ;
			frame(32'h0009 | (32'(i) << 13), 16, (i == 1) ? 16'h2000 : 16'h0008);
			overcurrent = 6'h04;
			cyc(dly - 50);
			`CHK(driverOn, 6'h04)
			cyc(100);
			`CHK(driverOn, 6'h00)
			overcurrent = 6'h00;
		end
		frame(32'h0008, 16, 16'h2000);
		`CHK(driverOn, 6'h00)
		frame(32'h0009, 16, 16'h2000);
		`CHK(driverOn, 6'h04)
		frame(32'h0008, 16, 16'h0008);
		// sleep and wake
		enable = 1'b0;
		cyc(10);
		`CHK(driverHiZ, 1'b1)
		`CHK(driverOn, 6'h00)
		enable = 1'b1;
		cyc(10);
		`CHK(driverHiZ, 1'b0)
		`CHK(driverOn, 6'h04)
		closeOut();
	end

	// watchdog well beyond the expected run length
	initial begin
		#2000000;
		numErrors++;
		closeOut();
	end
endmodule
`default_nettype wire
